// ### verilog/t1_pma_mmd_register_bank.sv
// Purpose: PMA management register bank of a 100BASE-T1 transceiver
// Assumes: Indirect access logic presents decoded requests on this clock
// Notes: Requests outside the PMA device space or unmapped read as zero, no hit
//
// Operation
// - Extended ability register one reads a fixed one in bit 11.
// - Extended ability register two reads one in bit 0, zeros elsewhere.
// - Role control bit 14 is read-write, master when one, reset from strap.
// - Test control bits 15:12 select normal or test modes 1, 2, 4, 5.
`timescale 1ns/100ps
module t1_pma_mmd_register_bank
    import pma_bank_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic role_strap,
    input mgmt_req_type req,
    output mgmt_rsp_type rsp,
    output logic role_master,
    output test_mode_type test_mode
);

    // ************************************************************
    // Strap synchroniser and access decode
    // ************************************************************
    logic strap_meta_r;
    logic strap_sync_r;
    logic role_r;
    logic [3:0] test_sel_r;
    logic space_ok;
    logic [15:0] rdata_nxt;
    logic hit_nxt;

    always_ff @(posedge clock)
    begin
        strap_meta_r <= role_strap;
        strap_sync_r <= strap_meta_r;
    end

    // Accesses with another device selection belong to other banks
    assign space_ok = (req.device_select == PMA_DEVICE_SPACE);

    // ************************************************************
    // Writable fields
    // ************************************************************
    // Strap is sampled while reset is held, through the synchroniser
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            role_r <= strap_sync_r;
        end
        else if (req.wr && space_ok && req.addr == ROLE_CONTROL_ADDR)
        begin
            role_r <= req.wdata[ROLE_BIT];
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            test_sel_r <= TEST_SEL_RESET;
        end
        else if (req.wr && space_ok && req.addr == TEST_MODE_CONTROL_ADDR)
        begin
            test_sel_r <= req.wdata[TEST_SEL_LSB +: 4];
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    always_comb
    begin
        rdata_nxt = 16'h0000;
        hit_nxt = space_ok;
        case (req.addr)
            EXT_ABILITY_ONE_ADDR: rdata_nxt = EXT_ABILITY_ONE_VALUE;
            EXT_ABILITY_TWO_ADDR: rdata_nxt = EXT_ABILITY_TWO_VALUE;
            ROLE_CONTROL_ADDR:
            begin
                rdata_nxt = ROLE_CONTROL_FIXED;
                rdata_nxt[ROLE_BIT] = role_r;
            end
            TEST_MODE_CONTROL_ADDR:
            begin
                rdata_nxt = TEST_MODE_FIXED;
                rdata_nxt[TEST_SEL_LSB +: 4] = test_sel_r;
            end
            default: hit_nxt = 1'b0;
        endcase
        if (!space_ok)
        begin
            rdata_nxt = 16'h0000;
        end
    end

    // Read data registered so the bus sees one-cycle latency
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rsp <= '0;
        end
        else
        begin
            rsp.rvalid <= req.rd;
            rsp.hit <= req.rd & hit_nxt;
            rsp.rdata <= req.rd ? rdata_nxt : 16'h0000;
        end
    end

    assign role_master = role_r;

    test_mode_decode u_decode
    (
        .transmit_test_pattern_select(test_sel_r),
        .mode(test_mode)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    AST_EXT1_VALUE: assert property (@(posedge clock) disable iff (rst)
        req.rd && space_ok && req.addr == EXT_ABILITY_ONE_ADDR
        |=> rsp.rvalid && rsp.rdata == 16'h0800)
        else $error("extended ability one read wrong");

    AST_EXT2_VALUE: assert property (@(posedge clock) disable iff (rst)
        req.rd && space_ok && req.addr == EXT_ABILITY_TWO_ADDR
        |=> rsp.rdata == 16'h0001)
        else $error("extended ability two read wrong");

    AST_ROLE_WRITE: assert property (@(posedge clock) disable iff (rst)
        req.wr && space_ok && req.addr == ROLE_CONTROL_ADDR
        |=> role_master == $past(req.wdata[14]))
        else $error("role bit did not take write");

    AST_ROLE_READBACK: assert property (@(posedge clock) disable iff (rst)
        req.rd && space_ok && req.addr == ROLE_CONTROL_ADDR
        |=> rsp.rdata == {1'b1, $past(role_master), 14'h0000})
        else $error("role control read wrong");

    AST_TEST_MODE5: assert property (@(posedge clock) disable iff (rst)
        req.wr && space_ok && req.addr == TEST_MODE_CONTROL_ADDR && req.wdata[15:12] == 4'hA
        |=> test_mode == TX_TEST_MODE5)
        else $error("test mode 5 not selected");

    // Every code outside the listed set must fall back, not one spot value
    AST_TEST_UNLISTED: assert property (@(posedge clock) disable iff (rst)
        req.wr && space_ok && req.addr == TEST_MODE_CONTROL_ADDR
        && req.wdata[TEST_SEL_LSB +: 4] != TEST_CODE_NORMAL
        && req.wdata[TEST_SEL_LSB +: 4] != TEST_CODE_MODE1
        && req.wdata[TEST_SEL_LSB +: 4] != TEST_CODE_MODE2
        && req.wdata[TEST_SEL_LSB +: 4] != TEST_CODE_MODE4
        && req.wdata[TEST_SEL_LSB +: 4] != TEST_CODE_MODE5
        |=> test_mode == TX_NORMAL)
        else $error("unlisted code not normal");

    AST_TEST_READBACK: assert property (@(posedge clock) disable iff (rst)
        req.rd && space_ok && req.addr == TEST_MODE_CONTROL_ADDR
        |=> rsp.rdata[11:0] == 12'h001)
        else $error("test control reserved bits wrong");

    AST_OTHER_SPACE: assert property (@(posedge clock) disable iff (rst)
        req.rd && !space_ok |=> rsp.rvalid && !rsp.hit && rsp.rdata == 16'h0000)
        else $error("foreign device space answered");

    AST_TEST_MODE1: assert property (@(posedge clock) disable iff (rst)
        req.wr && space_ok && req.addr == TEST_MODE_CONTROL_ADDR
        && req.wdata[TEST_SEL_LSB +: 4] == TEST_CODE_MODE1 |=> test_mode == TX_TEST_MODE1)
        else $error("test mode 1 not selected");

    AST_TEST_MODE2: assert property (@(posedge clock) disable iff (rst)
        req.wr && space_ok && req.addr == TEST_MODE_CONTROL_ADDR
        && req.wdata[TEST_SEL_LSB +: 4] == TEST_CODE_MODE2 |=> test_mode == TX_TEST_MODE2)
        else $error("test mode 2 not selected");

    AST_TEST_MODE4: assert property (@(posedge clock) disable iff (rst)
        req.wr && space_ok && req.addr == TEST_MODE_CONTROL_ADDR
        && req.wdata[TEST_SEL_LSB +: 4] == TEST_CODE_MODE4 |=> test_mode == TX_TEST_MODE4)
        else $error("test mode 4 not selected");

    AST_TEST_NORMAL: assert property (@(posedge clock) disable iff (rst)
        req.wr && space_ok && req.addr == TEST_MODE_CONTROL_ADDR
        && req.wdata[TEST_SEL_LSB +: 4] == TEST_CODE_NORMAL |=> test_mode == TX_NORMAL)
        else $error("normal operation not selected");

    AST_ROLE_HOLD: assert property (@(posedge clock) disable iff (rst)
        !(req.wr && space_ok && req.addr == ROLE_CONTROL_ADDR) |=> $stable(role_master))
        else $error("role bit changed without a write");

    AST_TEST_SEL_HOLD: assert property (@(posedge clock) disable iff (rst)
        !(req.wr && space_ok && req.addr == TEST_MODE_CONTROL_ADDR) |=> $stable(test_mode))
        else $error("test mode changed without a write");

    AST_FOREIGN_WRITE: assert property (@(posedge clock) disable iff (rst)
        req.wr && !space_ok |=> $stable(role_master) && $stable(test_mode))
        else $error("foreign write changed a field");

    // Checked only once the strap has had time to cross both flops
    AST_ROLE_RESET: assert property (@(posedge clock)
        rst && $past(rst) && $past(rst, 2) |=> role_master == $past(role_strap, 3))
        else $error("role did not take the strap in reset");

    AST_MODE_RESET: assert property (@(posedge clock)
        rst |=> test_mode == TX_NORMAL && !rsp.rvalid && !rsp.hit)
        else $error("reset left a mode or an answer");

    // Answer fields stand one cycle only, so the bus never sees stale data
    AST_READ_IDLE: assert property (@(posedge clock) disable iff (rst)
        !req.rd |=> !rsp.rvalid && !rsp.hit && rsp.rdata == 16'h0000)
        else $error("answer outside its cycle");

    AST_UNMAPPED: assert property (@(posedge clock) disable iff (rst)
        req.rd && space_ok && req.addr != EXT_ABILITY_ONE_ADDR
        && req.addr != EXT_ABILITY_TWO_ADDR && req.addr != ROLE_CONTROL_ADDR
        && req.addr != TEST_MODE_CONTROL_ADDR
        |=> rsp.rvalid && !rsp.hit && rsp.rdata == 16'h0000)
        else $error("unmapped register answered");

    AST_EXT2_HIT: assert property (@(posedge clock) disable iff (rst)
        req.rd && space_ok && req.addr == EXT_ABILITY_TWO_ADDR |=> rsp.rvalid && rsp.hit)
        else $error("extended ability two read missed");

endmodule

// ### common/pma_bank_pkg.sv
// Purpose: Constants and carriers for the PMA management register bank
// Assumes: 16-bit management registers addressed by a 16-bit register number
// Notes: Register numbers are those of the PMA device space
package pma_bank_pkg;

    // ************************************************************
    // Register numbers
    // ************************************************************
    localparam logic [4:0] PMA_DEVICE_SPACE = 5'h01;
    localparam logic [15:0] EXT_ABILITY_ONE_ADDR = 16'h000B;
    localparam logic [15:0] EXT_ABILITY_TWO_ADDR = 16'h0012;
    localparam logic [15:0] ROLE_CONTROL_ADDR = 16'h0834;
    localparam logic [15:0] TEST_MODE_CONTROL_ADDR = 16'h0836;

    // ************************************************************
    // Field positions and fixed values
    // ************************************************************
    localparam int EXTRA_ABILITY_BIT = 11;
    localparam int T1_SUPPORT_BIT = 0;
    localparam int ROLE_BIT = 14;
    localparam int TEST_SEL_LSB = 12;
    localparam logic [15:0] EXT_ABILITY_ONE_VALUE = 16'h0800;
    localparam logic [15:0] EXT_ABILITY_TWO_VALUE = 16'h0001;
    localparam logic [15:0] ROLE_CONTROL_FIXED = 16'h8000;
    localparam logic [15:0] TEST_MODE_FIXED = 16'h0001;
    localparam logic [3:0] TEST_SEL_RESET = 4'h0;

    // ************************************************************
    // Transmitter test pattern codes
    // ************************************************************
    localparam logic [3:0] TEST_CODE_NORMAL = 4'h0;
    localparam logic [3:0] TEST_CODE_MODE1 = 4'h2;
    localparam logic [3:0] TEST_CODE_MODE2 = 4'h4;
    localparam logic [3:0] TEST_CODE_MODE4 = 4'h8;
    localparam logic [3:0] TEST_CODE_MODE5 = 4'hA;

    typedef enum logic [2:0]
    {
        TX_NORMAL,
        TX_TEST_MODE1,
        TX_TEST_MODE2,
        TX_TEST_MODE4,
        TX_TEST_MODE5
    } test_mode_type;

    typedef struct packed
    {
        logic [4:0] device_select;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } mgmt_req_type;

    typedef struct packed
    {
        logic [15:0] rdata;
        logic rvalid;
        logic hit;
    } mgmt_rsp_type;

endpackage

// ### verilog/test_mode_decode.sv
// Purpose: Decode the transmit test pattern selection into a mode
// Assumes: Selection field is the four-bit register field
// Notes: Purely combinational
`timescale 1ns/100ps
module test_mode_decode
    import pma_bank_pkg::*;
(
    input wire logic [3:0] transmit_test_pattern_select,
    output test_mode_type mode
);

    always_comb
    begin
        case (transmit_test_pattern_select)
            TEST_CODE_MODE1: mode = TX_TEST_MODE1;
            TEST_CODE_MODE2: mode = TX_TEST_MODE2;
            TEST_CODE_MODE4: mode = TX_TEST_MODE4;
            TEST_CODE_MODE5: mode = TX_TEST_MODE5;
            // Unlisted codes must never drive a pattern onto the wire
            default: mode = TX_NORMAL;
        endcase
    end

endmodule

// ### bench/t1_pma_mmd_register_bank_test.sv
// Purpose: Self-checking bench for the PMA management register bank
// Assumes: One-cycle strobes; read answer exactly one cycle after the strobe
// Notes: Expected words are built from the register layout, never from outputs
`timescale 1ns/100ps
module t1_pma_mmd_register_bank_test import pma_bank_pkg::*;;
logic clock = 1'b0;
logic rst = 1'b1;
logic role_strap = 1'b1;
mgmt_req_type req = '0;
mgmt_rsp_type rsp;
logic role_master;
test_mode_type test_mode;
int n_errors = 0;
int checks = 0;

t1_pma_mmd_register_bank u_t1_pma_mmd_register_bank
(
    .clock(clock),
    .rst(rst),
    .role_strap(role_strap),
    .req(req),
    .rsp(rsp),
    .role_master(role_master),
    .test_mode(test_mode)
);

initial
begin
    forever #2 clock = ~clock;
end

// ********************
// Drivers and checks
// ********************
task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
        n_errors++;
        $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
endtask

task automatic final_report();
    if (n_errors == 0 && checks > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask

task automatic write_reg(input logic [4:0] sp, input logic [15:0] a, input logic [15:0] d);
    @(posedge clock) #1;
    req = '{sp, a, d, 1'b1, 1'b0};
    @(posedge clock) #1;
    req = '0;
endtask

// Answer is taken at the edge after the strobe, where it stands for one cycle
task automatic read_check(input string what, input logic [4:0] sp, input logic [15:0] a,
    input logic [15:0] exp, input logic hit);
    @(posedge clock) #1;
    req = '{sp, a, 16'h0000, 1'b0, 1'b1};
    @(posedge clock) #1;
    req = '0;
    check({what, " valid"}, {15'h0000, rsp.rvalid}, 16'h0001);
    check({what, " hit"}, {15'h0000, rsp.hit}, {15'h0000, hit});
    check(what, rsp.rdata, exp);
endtask

// ********************
// Scenarios
// ********************
task automatic reset_values();
    check("role out", {15'h0000, role_master}, 16'h0001);
    read_check("ext one", 5'h01, 16'h000B, 16'h0800, 1'b1);
    read_check("ext two", 5'h01, 16'h0012, 16'h0001, 1'b1);
    read_check("role", 5'h01, 16'h0834, 16'hC000, 1'b1);
    read_check("test sel", 5'h01, 16'h0836, 16'h0001, 1'b1);
endtask

task automatic read_only_writes();
    write_reg(5'h01, 16'h000B, 16'hFFFF);
    write_reg(5'h01, 16'h0012, 16'hFFFE);
    read_check("ext one ro", 5'h01, 16'h000B, 16'h0800, 1'b1);
    read_check("ext two ro", 5'h01, 16'h0012, 16'h0001, 1'b1);
endtask

task automatic role_scenario();
    write_reg(5'h01, 16'h0834, 16'h3FFF);
    check("role out", {15'h0000, role_master}, 16'h0000);
    read_check("role clear", 5'h01, 16'h0834, 16'h8000, 1'b1);
    write_reg(5'h01, 16'h0834, 16'h4000);
    check("role out", {15'h0000, role_master}, 16'h0001);
    read_check("role set", 5'h01, 16'h0834, 16'hC000, 1'b1);
endtask

// Last entry is an unlisted code, left in place for the foreign-space check
task automatic test_modes();
    logic [3:0] codes [6] = '{4'h0, 4'h2, 4'h4, 4'h8, 4'hA, 4'h6};
    test_mode_type modes [6] = '{TX_NORMAL, TX_TEST_MODE1, TX_TEST_MODE2,
        TX_TEST_MODE4, TX_TEST_MODE5, TX_NORMAL};
    for (int i = 0; i < 6; i++)
    begin
        write_reg(5'h01, 16'h0836, {codes[i], 12'hFFE});
        check("mode", {13'h0000, test_mode}, {13'h0000, modes[i]});
        read_check("test sel", 5'h01, 16'h0836, {codes[i], 12'h001}, 1'b1);
    end
endtask

task automatic foreign_space();
    write_reg(5'h02, 16'h0836, 16'hA000);
    write_reg(5'h02, 16'h0834, 16'h0000);
    check("role kept", {15'h0000, role_master}, 16'h0001);
    read_check("foreign", 5'h02, 16'h000B, 16'h0000, 1'b0);
    read_check("unmapped", 5'h01, 16'h0835, 16'h0000, 1'b0);
    read_check("sel kept", 5'h01, 16'h0836, 16'h6001, 1'b1);
endtask

task automatic strap_reset();
    role_strap = 1'b0;
    rst = 1'b1;
    repeat (12) @(posedge clock);
    #1 rst = 1'b0;
    check("strap", {15'h0000, role_master}, 16'h0000);
    check("mode rst", {13'h0000, test_mode}, {13'h0000, TX_NORMAL});
    read_check("role strap", 5'h01, 16'h0834, 16'h8000, 1'b1);
endtask

initial
begin
    repeat (12) @(posedge clock);
    #1 rst = 1'b0;
    reset_values();
    read_only_writes();
    role_scenario();
    test_modes();
    foreign_space();
    strap_reset();
    final_report();
end

initial
begin
    #100000;
    n_errors++;
    final_report();
end
endmodule
